/* File: hdl/fdh_pkg.sv */
// constants and carriers for the division helper datapath
package fdh_pkg;
   typedef enum logic [2:0] {
      FDH_OP_FIXUP_D,
      FDH_OP_SCALE_S,
      FDH_OP_SCALE_D,
      FDH_OP_FMAS_S,
      FDH_OP_FMAS_D,
      FDH_OP_MAD_U,
      FDH_OP_MAD_I
   } fdh_op_type;

   localparam logic [63:0] FDH_DEF_NAN_D = 64'hfff8_0000_0000_0000;
   localparam logic [63:0] FDH_DEF_NAN_S = 64'h0000_0000_ffc0_0000;
   localparam int FDH_UFLOW_LIM = -1075;
   localparam int FDH_EXP_MAX_D = 2047;
   localparam int FDH_EXP_MAX_S = 255;
   localparam int FDH_BIAS_D = 1023;
   localparam int FDH_BIAS_S = 127;
   localparam int FDH_THR_S = 96;
   localparam int FDH_THR_D = 768;
   localparam int FDH_SCL_S = 64;
   localparam int FDH_SCL_D = 128;
   localparam int FDH_TINY_S = 23;
   localparam int FDH_TINY_D = 53;
   localparam int FDH_RDEN_S = 253;
   localparam int FDH_RDEN_D = 2045;
   localparam int FDH_QDEN_S = -126;
   localparam int FDH_QDEN_D = -1022;
   localparam int FDH_FMAS_S = 32;
   localparam int FDH_FMAS_D = 64;
   localparam int FDH_QUIET_BIT = 51;
   localparam int FDH_PT = 104;
   localparam logic FDH_MASK_RST = 1'b0;

   typedef struct packed {
      logic valid;
      fdh_op_type op;
      logic flush_out;
      logic [63:0] s0;
      logic [63:0] s1;
      logic [63:0] s2;
   } fdh_req_type;

   typedef struct packed {
      logic valid;
      logic [63:0] data;
      logic mask;
      logic invalid;
      logic denorm;
      logic div_zero;
   } fdh_rsp_type;
endpackage

/* File: hdl/fdh_alu.sv */
// one lane of the division helper datapath, one cycle from request to result
`timescale 1ns/1ps
`default_nettype none
module fdh_alu (
   input wire logic clk,
   input wire logic rst,
   input wire fdh_pkg::fdh_req_type req,
   output var fdh_pkg::fdh_rsp_type rsp
);

   ////////////////////////////////////////////////////////////////
   // field helpers, d selects double layout
   function automatic int ex(logic [63:0] x, logic d);
      return d ? int'(x[62:52]) : int'(x[30:23]);
   endfunction

   function automatic logic [51:0] fr(logic [63:0] x, logic d);
      return d ? x[51:0] : {x[22:0], 29'h0};
   endfunction

   function automatic logic sg(logic [63:0] x, logic d);
      return d ? x[63] : x[31];
   endfunction

   function automatic int emax(logic d);
      return d ? fdh_pkg::FDH_EXP_MAX_D : fdh_pkg::FDH_EXP_MAX_S;
   endfunction

   function automatic logic is_nan(logic [63:0] x, logic d);
      return ex(x, d) == emax(d) && fr(x, d) != 52'h0;
   endfunction

   function automatic logic is_inf(logic [63:0] x, logic d);
      return ex(x, d) == emax(d) && fr(x, d) == 52'h0;
   endfunction

   function automatic logic is_zero(logic [63:0] x, logic d);
      return ex(x, d) == 0 && fr(x, d) == 52'h0;
   endfunction

   function automatic logic [63:0] def_nan(logic d);
      return d ? fdh_pkg::FDH_DEF_NAN_D : fdh_pkg::FDH_DEF_NAN_S;
   endfunction

   // position of the leading one, -1 when empty
   function automatic int msb(logic [107:0] v);
      int p;
      p = -1;
      for (int i = 0; i < 108; i++) begin
         if (v[i]) begin
            p = i;
         end
      end
      return p;
   endfunction

   // build a value from sign, biased exponent and mantissa (hidden bit 52);
   // truncates, so in-range results round toward zero; an exponent at or above the maximum gives infinity
   function automatic logic [63:0] pack(logic s, int e, logic [52:0] m, logic d, logic fl);
      int sh;
      logic [52:0] mm;
      mm = m;
      if (e >= emax(d)) begin
         e = emax(d);
         mm = 53'h0;
      end else if (e < 1) begin
         sh = 1 - e;
         mm = (fl || sh > 53) ? 53'h0 : m >> sh;
         e = 0;
      end
      return d ? {s, 11'(e), mm[51:0]} : {32'h0, s, 8'(e), mm[51:29]};
   endfunction

   // multiply by two to the k, denormal inputs normalised first
   function automatic logic [63:0] ldexp(logic [63:0] x, logic d, int k);
      int e;
      int p;
      logic [107:0] m;
      if (ex(x, d) == emax(d) || is_zero(x, d)) begin
         return x;
      end
      e = (ex(x, d) == 0) ? 1 : ex(x, d);
      m = {55'h0, ex(x, d) != 0, fr(x, d)};
      p = msb(m);
      m = m << (52 - p);
      return pack(sg(x, d), e - (52 - p) + k, m[52:0], d, 1'b0);
   endfunction

   // fused a*b+c, exponent raised by k; one truncation at the end
   function automatic logic [63:0] fma(logic [63:0] a, logic [63:0] b, logic [63:0] c,
                                       logic d, int k, logic fl);
      int ep;
      int ec;
      int er;
      int sh;
      int p;
      logic sp;
      logic sc;
      logic sr;
      logic sb;
      logic ss;
      logic pinf;
      logic [107:0] pm;
      logic [107:0] cm;
      logic [107:0] big;
      logic [107:0] sml;
      logic [107:0] sum;
      logic [107:0] nm;
      sp = sg(a, d) ^ sg(b, d);
      sc = sg(c, d);
      pinf = is_inf(a, d) || is_inf(b, d);
      if (is_nan(a, d) || is_nan(b, d) || is_nan(c, d) ||
          (pinf && (is_zero(a, d) || is_zero(b, d))) ||
          (pinf && is_inf(c, d) && sp != sc)) begin
         return def_nan(d);
      end
      if (pinf || is_inf(c, d)) begin
         return pack(pinf ? sp : sc, emax(d), 53'h0, d, 1'b0);
      end
      // product point at bit 104, addend aligned to it
      pm = {2'h0, 106'({ex(a, d) != 0, fr(a, d)}) * 106'({ex(b, d) != 0, fr(b, d)})};
      cm = {3'h0, ex(c, d) != 0, fr(c, d), 52'h0};
      ep = ((ex(a, d) == 0) ? 1 : ex(a, d)) + ((ex(b, d) == 0) ? 1 : ex(b, d))
           - (d ? fdh_pkg::FDH_BIAS_D : fdh_pkg::FDH_BIAS_S);
      ec = (ex(c, d) == 0) ? 1 : ex(c, d);
      if (ep >= ec) begin
         big = pm;
         sb = sp;
         sh = ep - ec;
         sml = (sh > 107) ? 108'h0 : cm >> sh;
         ss = sc;
         er = ep;
      end else begin
         big = cm;
         sb = sc;
         sh = ec - ep;
         sml = (sh > 107) ? 108'h0 : pm >> sh;
         ss = sp;
         er = ec;
      end
      if (sb == ss) begin
         sum = big + sml;
         sr = sb;
      end else if (big >= sml) begin
         sum = big - sml;
         sr = sb;
      end else begin
         sum = sml - big;
         sr = ss;
      end
      if (sum == 108'h0) begin
         return pack(sp & sc, 0, 53'h0, d, 1'b0);
      end
      p = msb(sum);
      nm = (p >= 52) ? sum >> (p - 52) : sum << (52 - p);
      return pack(sr, er + p - fdh_pkg::FDH_PT + k, nm[52:0], d, fl);
   endfunction

   ////////////////////////////////////////////////////////////////
   // result and lane mask next values
   fdh_pkg::fdh_rsp_type next_rsp;
   logic [63:0] s0;
   logic [63:0] s1;
   logic [63:0] s2;
   logic dbl;
   logic so;
   int en;
   int ed;
   int thr;
   int scl;
   int tiny;
   logic rden;
   logic qden;
   logic [64:0] mu;
   logic signed [65:0] ms;

   always_comb begin
      s0 = req.s0;
      s1 = req.s1;
      s2 = req.s2;
      dbl = req.op != fdh_pkg::FDH_OP_SCALE_S && req.op != fdh_pkg::FDH_OP_FMAS_S;
      so = sg(s1, dbl) ^ sg(s2, dbl);
      en = ex(s2, dbl);
      ed = ex(s1, dbl);
      thr = dbl ? fdh_pkg::FDH_THR_D : fdh_pkg::FDH_THR_S;
      scl = dbl ? fdh_pkg::FDH_SCL_D : fdh_pkg::FDH_SCL_S;
      tiny = dbl ? fdh_pkg::FDH_TINY_D : fdh_pkg::FDH_TINY_S;
      // estimates from exponents only; mantissas can move them by one
      rden = ed >= (dbl ? fdh_pkg::FDH_RDEN_D : fdh_pkg::FDH_RDEN_S);
      qden = en - ed < (dbl ? fdh_pkg::FDH_QDEN_D : fdh_pkg::FDH_QDEN_S);
      mu = {1'b0, 64'({32'h0, s0[31:0]} * {32'h0, s1[31:0]})} + {1'b0, s2};
      ms = 66'($signed({{34{s0[31]}}, s0[31:0]}) * $signed({{34{s1[31]}}, s1[31:0]}))
           + $signed({{2{s2[63]}}, s2});
      next_rsp = rsp;
      next_rsp.valid = req.valid;
      next_rsp.invalid = 1'b0;
      next_rsp.denorm = 1'b0;
      next_rsp.div_zero = 1'b0;
      if (req.valid) begin
         case (req.op)
            fdh_pkg::FDH_OP_FIXUP_D: begin
               if (is_nan(s2, 1'b1)) begin
                  next_rsp.data = s2 | (64'h1 << fdh_pkg::FDH_QUIET_BIT);
               end else if (is_nan(s1, 1'b1)) begin
                  next_rsp.data = s1 | (64'h1 << fdh_pkg::FDH_QUIET_BIT);
               end else if (is_zero(s1, 1'b1) && is_zero(s2, 1'b1)) begin
                  next_rsp.data = fdh_pkg::FDH_DEF_NAN_D;
               end else if (is_inf(s1, 1'b1) && is_inf(s2, 1'b1)) begin
                  next_rsp.data = fdh_pkg::FDH_DEF_NAN_D;
               end else if (is_zero(s1, 1'b1) || is_inf(s2, 1'b1)) begin
                  next_rsp.data = {so, 11'h7ff, 52'h0};
               end else if (is_inf(s1, 1'b1) || is_zero(s2, 1'b1)) begin
                  next_rsp.data = {so, 63'h0};
               end else if (en - ed < fdh_pkg::FDH_UFLOW_LIM) begin
                  next_rsp.data = {so, 63'h0};
               end else if (ed == fdh_pkg::FDH_EXP_MAX_D) begin
                  next_rsp.data = {so, 11'h7ff, 52'h0};
               end else begin
                  next_rsp.data = {so, s0[62:0]};
               end
               // signalling nans and the two indeterminate forms
               next_rsp.invalid = (is_nan(s1, 1'b1) && !s1[fdh_pkg::FDH_QUIET_BIT]) ||
                                  (is_nan(s2, 1'b1) && !s2[fdh_pkg::FDH_QUIET_BIT]) ||
                                  (is_zero(s1, 1'b1) && is_zero(s2, 1'b1)) ||
                                  (is_inf(s1, 1'b1) && is_inf(s2, 1'b1));
               next_rsp.denorm = (ed == 0 && !is_zero(s1, 1'b1)) ||
                                 (en == 0 && !is_zero(s2, 1'b1));
               next_rsp.div_zero = is_zero(s1, 1'b1) && en != fdh_pkg::FDH_EXP_MAX_D &&
                                   !is_zero(s2, 1'b1);
            end
            fdh_pkg::FDH_OP_SCALE_S, fdh_pkg::FDH_OP_SCALE_D: begin
               // the compares below lean on s0 matching s1 or s2
               next_rsp.mask = 1'b0;
               next_rsp.data = dbl ? s0 : {32'h0, s0[31:0]};
               if (is_zero(s2, dbl) || is_zero(s1, dbl)) begin
                  next_rsp.data = def_nan(dbl);
               end else if (en - ed >= thr) begin
                  next_rsp.mask = 1'b1;
                  if (next_rsp.data == (dbl ? s1 : {32'h0, s1[31:0]})) begin
                     next_rsp.data = ldexp(s0, dbl, scl);
                  end
               end else if (ed == 0) begin
                  next_rsp.data = ldexp(s0, dbl, scl);
               end else if (rden && qden) begin
                  next_rsp.mask = 1'b1;
                  if (next_rsp.data == (dbl ? s1 : {32'h0, s1[31:0]})) begin
                     next_rsp.data = ldexp(s0, dbl, scl);
                  end
               end else if (rden) begin
                  next_rsp.data = ldexp(s0, dbl, -scl);
               end else if (qden) begin
                  next_rsp.mask = 1'b1;
                  if (next_rsp.data == (dbl ? s2 : {32'h0, s2[31:0]})) begin
                     next_rsp.data = ldexp(s0, dbl, scl);
                  end
               end else if (en <= tiny) begin
                  next_rsp.data = ldexp(s0, dbl, scl);
               end
            end
            fdh_pkg::FDH_OP_FMAS_S: begin
               next_rsp.data = fma(s0, s1, s2, 1'b0, rsp.mask ? fdh_pkg::FDH_FMAS_S : 0,
                                   req.flush_out);
            end
            fdh_pkg::FDH_OP_FMAS_D: begin
               next_rsp.data = fma(s0, s1, s2, 1'b1, rsp.mask ? fdh_pkg::FDH_FMAS_D : 0,
                                   req.flush_out);
            end
            fdh_pkg::FDH_OP_MAD_U: begin
               next_rsp.data = mu[63:0];
               next_rsp.mask = mu[64];
            end
            fdh_pkg::FDH_OP_MAD_I: begin
               next_rsp.data = ms[63:0];
               next_rsp.mask = ms[64] ^ ms[63];
            end
            default: begin
               next_rsp.data = 64'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // result register; mask persists between operations
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp <= '0;
         rsp.mask <= fdh_pkg::FDH_MASK_RST;
      end else begin
         rsp <= next_rsp;
      end
   end

endmodule
`default_nettype wire

/* File: tb/fdh_issue_model.sv */
// issue-side model that hands operations to one lane
`timescale 1ns/1ps
`default_nettype none
module fdh_issue_model (
   input wire logic clk,
   output var fdh_pkg::fdh_req_type req
);
   initial req = '0;

   ////////////////////////////////////////
   // request stands through the taking edge, callers start on an edge
   task automatic issue(fdh_pkg::fdh_op_type op, logic fl, logic [63:0] a, b, c);
      req <= '{1'b1, op, fl, a, b, c};
      @(posedge clk);
   endtask

   // idle operands flip so a stale value never passes for a live one
   task automatic idle();
      req.valid <= 1'b0;
      req.s0 <= ~req.s0;
      req.s1 <= ~req.s1;
      req.s2 <= ~req.s2;
   endtask
endmodule
`default_nettype wire

/* File: tb/fdh_alu_assertions.sv */
// port-level checks of the division helper lane
`timescale 1ns/1ps
`default_nettype none
module fdh_alu_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire fdh_pkg::fdh_req_type req,
   input wire fdh_pkg::fdh_rsp_type rsp
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   // double fixup request in flight
   wire logic fix = req.valid && req.op == fdh_pkg::FDH_OP_FIXUP_D;

   ////////////////////////////////////////
   a_answer_next: assert property (rsp.valid == $past(req.valid && !rst))
      else $error("answer pulse not one cycle after request");
   a_nan_quieted: assert property (
      fix && req.s2[62:52] == 11'h7ff && req.s2[51:0] != 0 |=> rsp.data == ($past(req.s2) | 64'h0008_0000_0000_0000))
      else $error("nan numerator not quieted");
   a_zero_by_zero: assert property (
      fix && req.s1[62:0] == 0 && req.s2[62:0] == 0 |=> rsp.data == fdh_pkg::FDH_DEF_NAN_D && rsp.invalid)
      else $error("zero over zero wrong");
   a_div_by_zero: assert property (
      fix && req.s1[62:0] == 0 && req.s2[62:52] != 11'h7ff && req.s2[62:0] != 0
      |=> rsp.data == {$past(req.s1[63]) ^ $past(req.s2[63]), 63'h7ff0_0000_0000_0000} && rsp.div_zero)
      else $error("divide by zero wrong");
   a_xor_sign: assert property (
      fix && req.s1[62:52] != 11'h7ff && req.s2[62:52] != 11'h7ff && (req.s1[62:0] != 0 || req.s2[62:0] != 0)
      |=> rsp.data[63] == ($past(req.s1[63]) ^ $past(req.s2[63])))
      else $error("fixup sign wrong");
   a_flags_quiet: assert property (
      req.valid && req.op != fdh_pkg::FDH_OP_FIXUP_D |=> !(rsp.invalid || rsp.denorm || rsp.div_zero))
      else $error("flags raised outside fixup");
   a_prescale_zero: assert property (
      req.valid && req.op == fdh_pkg::FDH_OP_SCALE_S && req.s1[30:0] == 0
      |=> !rsp.mask && rsp.data == fdh_pkg::FDH_DEF_NAN_S)
      else $error("prescale zero not nan");
   a_mad_unsigned: assert property (
      req.valid && req.op == fdh_pkg::FDH_OP_MAD_U
      |=> {rsp.mask, rsp.data} == 65'($past(req.s0[31:0])) * 65'($past(req.s1[31:0])) + 65'($past(req.s2)))
      else $error("unsigned multiply-accumulate wrong");
   // a reset edge clears the result on purpose, so it opens no attempt
   a_result_holds: assert property (!req.valid && !rst |=> $stable(rsp.data) && $stable(rsp.mask))
      else $error("result moved without request");

   // main scenarios reached
   c_mask_set: cover property (rsp.valid && rsp.mask);
   c_div_zero: cover property (rsp.valid && rsp.div_zero);
   c_back_to_back: cover property (req.valid && req.op == fdh_pkg::FDH_OP_SCALE_S ##1
      req.valid && req.op == fdh_pkg::FDH_OP_FMAS_S);
endmodule
bind fdh_alu fdh_alu_assertions u_chk (.clk(clk), .rst(rst), .req(req), .rsp(rsp));
`default_nettype wire

/* File: tb/fdh_alu_bench.sv */
// self-checking bench for one division helper lane
`timescale 1ns/1ps
`default_nettype none
module fdh_alu_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   fdh_pkg::fdh_req_type req;
   fdh_pkg::fdh_rsp_type rsp;

   fdh_issue_model m (.clk(clk), .req(req));
   fdh_alu dut (.clk(clk), .rst(rst), .req(req), .rsp(rsp));

   // 25 MHz core clock
   always #20 clk = ~clk;

   // hang guard, the run needs a few hundred cycles at most
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         test_done();
      end
   end

   ////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [64:0] exp, logic [64:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // top 16 bits plus low nibble keeps double operands short
   function automatic logic [63:0] h(logic [15:0] t, logic [3:0] l = 4'h0);
      return {t, 44'h0, l};
   endfunction

   // one op, answer sampled after the taking edge settles
   task automatic run(fdh_pkg::fdh_op_type op, logic fl, logic [63:0] a, b, c);
      @(posedge clk);
      m.issue(op, fl, a, b, c);
      m.idle();
      #1;
   endtask

   task automatic fx(logic [63:0] q, d, n, e, logic [2:0] f);
      run(fdh_pkg::FDH_OP_FIXUP_D, 1'b0, q, d, n);
      chk("fixup data", 65'(e), 65'(rsp.data));
      chk("fixup flags", 65'(f), 65'({rsp.invalid, rsp.denorm, rsp.div_zero}));
   endtask

   // input to scale is always a copy of denominator or numerator
   task automatic ss(logic [31:0] q, d, n, e, logic k);
      run(fdh_pkg::FDH_OP_SCALE_S, 1'b0, {32'h0, q}, {32'h0, d}, {32'h0, n});
      chk("prescale s", {k, 32'h0, e}, {rsp.mask, rsp.data});
   endtask

   task automatic sd(logic [63:0] q, d, n, e, logic k);
      run(fdh_pkg::FDH_OP_SCALE_D, 1'b0, q, d, n);
      chk("prescale d", {k, e}, {rsp.mask, rsp.data});
   endtask

   ////////////////////////////////////////
   task automatic t_walk();
      run(fdh_pkg::FDH_OP_MAD_U, 1'b0, 64'h3, 64'h5, 64'h1);
      chk("walk valid", 65'h1, 65'(rsp.valid));
      chk("walk sum", 65'h0010, {rsp.mask, rsp.data});
      @(posedge clk);
      #1;
      chk("walk pulse", 65'h0, 65'(rsp.valid));
      chk("walk hold", 65'h0010, {rsp.mask, rsp.data});
   endtask

   task automatic t_mad();
      run(fdh_pkg::FDH_OP_MAD_U, 1'b0, 64'hffff_ffff, 64'hffff_ffff, '1);
      chk("mad u carry", 65'h1_ffff_fffe_0000_0000, {rsp.mask, rsp.data});
      run(fdh_pkg::FDH_OP_MAD_I, 1'b0, 64'hffff_fffe, 64'h3, 64'ha);
      chk("mad i", 65'h4, {rsp.mask, rsp.data});
      run(fdh_pkg::FDH_OP_MAD_I, 1'b0, 64'hffff_ffff, 64'h1, h(16'h8000));
      chk("mad i carry", 65'h1_7fff_ffff_ffff_ffff, {rsp.mask, rsp.data});
   endtask

   task automatic t_fixup();
      fx(h(16'h4000), h(16'h7ff8), h(16'h7ff0, 4'h1), h(16'h7ff8, 4'h1), 3'b100);
      fx(h(16'h4000), h(16'hfff0, 4'h2), h(16'h3ff0), h(16'hfff8, 4'h2), 3'b100);
      fx(h(16'h4000), h(16'h8000), h(16'h0000), h(16'hfff8), 3'b100);
      fx(h(16'h4000), h(16'hfff0), h(16'h7ff0), h(16'hfff8), 3'b100);
      fx(h(16'h4000), h(16'h0000), h(16'hc000), h(16'hfff0), 3'b001);
      fx(h(16'h4000), h(16'h3ff0), h(16'hfff0), h(16'hfff0), 3'b000);
      fx(h(16'h4000), h(16'hfff0), h(16'h3ff0), h(16'h8000), 3'b000);
      fx(h(16'h4000), h(16'h4350), h(16'h8010), h(16'h8000), 3'b000);
      fx(h(16'h4000), h(16'h4340), h(16'h8010), h(16'hc000), 3'b000);
      fx(h(16'h4000), h(16'h0000, 4'h1), h(16'h3ff0), h(16'h4000), 3'b010);
   endtask

   task automatic t_scale();
      ss(32'h3f80_0000, 32'h3f80_0000, 32'h6f80_0000, 32'h5f80_0000, 1'b1);
      ss(32'h3f80_0000, 32'h3f80_0000, 32'h6f00_0000, 32'h3f80_0000, 1'b0);
      ss(32'h6f80_0000, 32'h3f80_0000, 32'h6f80_0000, 32'h6f80_0000, 1'b1);
      ss(32'h2f80_0000, 32'h0000_0001, 32'h2f80_0000, 32'h4f80_0000, 1'b0);
      ss(32'h3200_0000, 32'h7e80_0000, 32'h3200_0000, 32'h3200_0000, 1'b1);
      ss(32'h7e80_0000, 32'h7e80_0000, 32'h7e80_0000, 32'h5e80_0000, 1'b0);
      ss(32'h0b80_0000, 32'h3f80_0000, 32'h0b80_0000, 32'h2b80_0000, 1'b0);
      ss(32'h2300_0000, 32'h6400_0000, 32'h2300_0000, 32'h4300_0000, 1'b1);
      ss(32'h3f80_0000, 32'h0000_0000, 32'h3f80_0000, 32'hffc0_0000, 1'b0);
      sd(h(16'h3ff0), h(16'h3ff0), h(16'h6ff0), h(16'h47f0), 1'b1);
      sd(h(16'h2ff0), h(16'h0000, 4'h1), h(16'h2ff0), h(16'h37f0), 1'b0);
      sd(h(16'h7fd0), h(16'h7fd0), h(16'h7fd0), h(16'h77d0), 1'b0);
      sd(h(16'h0350), h(16'h3ff0), h(16'h0350), h(16'h0b50), 1'b0);
      sd(h(16'h3ff0), h(16'h0000), h(16'h3ff0), h(16'hfff8), 1'b0);
   endtask

   // scale then fma back to back: the fresh mask must be seen
   task automatic t_fmas();
      @(posedge clk);
      m.issue(fdh_pkg::FDH_OP_SCALE_S, 1'b0, 64'h3f80_0000, 64'h3f80_0000, 64'h6f80_0000);
      m.issue(fdh_pkg::FDH_OP_FMAS_S, 1'b0, 64'h3f80_0000, 64'h4000_0000, 64'h3f80_0000);
      m.idle();
      #1;
      chk("fmas s scaled", 65'h5040_0000, 65'(rsp.data));
      run(fdh_pkg::FDH_OP_MAD_U, 1'b0, 64'h3, 64'h5, 64'h1);
      run(fdh_pkg::FDH_OP_FMAS_S, 1'b0, 64'h3f80_0000, 64'h4000_0000, 64'h3f80_0000);
      chk("fmas s plain", 65'h4040_0000, 65'(rsp.data));
      run(fdh_pkg::FDH_OP_FMAS_S, 1'b0, 64'h0001, 64'h4000_0000, 64'h0);
      chk("fmas denorm in", 65'h0002, 65'(rsp.data));
      run(fdh_pkg::FDH_OP_FMAS_S, 1'b1, 64'h0001, 64'h4000_0000, 64'h0);
      chk("fmas flush out", 65'h0, 65'(rsp.data));
      run(fdh_pkg::FDH_OP_MAD_U, 1'b0, 64'hffff_ffff, 64'hffff_ffff, '1);
      run(fdh_pkg::FDH_OP_FMAS_D, 1'b0, h(16'h3ff0), h(16'h4000), h(16'h3ff0));
      chk("fmas d scaled", 65'(h(16'h4408)), 65'(rsp.data));
   endtask

   // reset in mid-run must drop the carry mask and the result
   task automatic t_reset();
      run(fdh_pkg::FDH_OP_MAD_U, 1'b0, 64'hffff_ffff, 64'hffff_ffff, '1);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("reset clears", 65'h0, {rsp.mask, rsp.data});
   endtask

   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_walk();
      t_mad();
      t_fixup();
      t_scale();
      t_fmas();
      t_reset();
      t_walk();
      test_done();
   end
endmodule
`default_nettype wire
